// ==== dsm_defines.svh ====
// Register offsets, reset values, error numbers and timing counts for the drive status monitor bank
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH
`define DSM_OFF_FREQ      4'h0
`define DSM_OFF_CURR      4'h1
`define DSM_OFF_VOLT      4'h2
`define DSM_OFF_HIST0     4'h3
`define DSM_OFF_HIST1     4'h4
`define DSM_OFF_HIST2     4'h5
`define DSM_OFF_HIST3     4'h6
`define DSM_OFF_DIAG      4'h7
`define DSM_OFF_STATUS    4'h8
`define DSM_OFF_MASK      4'h9
`define DSM_OFF_CONTROL   4'ha
`define DSM_RST_WORD      16'h0000
`define DSM_NO_ALARM      8'h00
`define DSM_ERR_BAD_INSTR 8'h0a
`define DSM_ERR_PARAM     8'h0b
`define DSM_ERR_OVERRUN   8'h16
`define DSM_ERR_NO_END    8'h18
`define DSM_FREQ_STEP     16'h000a
`define DSM_FLASH_NS      250000000
`define DSM_CLK_NS        20
`define DSM_FLASH_CYC     (`DSM_FLASH_NS / `DSM_CLK_NS)
`define DSM_STAT_W        3
`define DSM_STAT_HIST     0
`define DSM_STAT_DIAG     1
`define DSM_STAT_SCAN     2
`endif

// ==== dsm_pkg.sv ====
// Types shared by the drive status monitor bank
package dsm_pkg;
    // Live monitor sample from the drive
    typedef struct packed {
        logic [15:0] freq; // 0.01 Hz units
        logic [15:0] curr; // 0.01 A units
        logic [15:0] volt; // 0.1 V units
    } dsm_monitor_t;
    // Fault reports raised during a scan
    typedef struct packed {
        logic bad_instruction_error;
        logic param_error;
        logic scan_overrun_error;
        logic missing_scan_end_error;
    } dsm_diag_t;
    // Scan controller state
    typedef enum logic [2:0] {
        DSM_RUN   = 3'b001,
        DSM_SCAN  = 3'b010,
        DSM_STOP  = 3'b100
    } dsm_state_t;
endpackage

// ==== dsm_error_history.sv ====
// Eight-entry error code history, newest first, packed two codes per word
`timescale 1ns/1ps
module dsm_error_history
    import dsm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        push,      // Record a new code
    input  wire logic [7:0]  code,      // Code to record
    input  wire logic        publish,   // Copy entries to visible words
    output logic [63:0]      words      // Four packed words, word 0 lowest
);
    `include "dsm_defines.svh"
    logic [7:0] entry [0:7];            // Internal shift history
    genvar g;
    // Shift older on a new code, newest in slot 0
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                entry[i] <= `DSM_NO_ALARM;
            end
        end else if (push && code != `DSM_NO_ALARM) begin
            entry[0] <= code;
            for (int i = 1; i < 8; i++) begin
                entry[i] <= entry[i-1];
            end
        end
    end
    // Even entry low byte, odd entry high byte; refreshed at end of scan only
    generate
        for (g = 0; g < 4; g++) begin : g_pack
            always_ff @(posedge clk) begin
                if (rst) begin
                    words[16*g +: 16] <= `DSM_RST_WORD;
                end else if (publish) begin
                    words[16*g +: 16] <= {entry[2*g+1], entry[2*g]};
                end
            end
        end
    endgenerate
endmodule

// ==== dsm_monitor_bank.sv ====
// Drive status monitor bank with Avalon-MM register access
`timescale 1ns/1ps
// Summary of operation
// - Refresh monitors and history at every scan end
// - Monitor registers read-only, always readable
// - Frequency monitor counts 0.01 Hz units
// - Current monitor counts 0.01 A units
// - Voltage monitor counts 0.1 V units
// - Output frequency really steps by 0.1 Hz
// - Keep eight most recent error codes
// - Two codes per word, even entry low
// - Eight-bit codes, zero means no alarm
// - Operation error stores self-diagnostic number
// - Run indicator flashes on diagnostic error
// - Error 10 for bad instruction or device
// - Error 11 for bad program capacity setting
// - Error 22 when scan overruns watchdog
// - Error 24 when scan end missing
// - Operand checks gated by instruction class
// - Error stop clears outputs, holds others
module dsm_monitor_bank
    import dsm_pkg::*;
#(
    parameter int FLASH_CYC = `DSM_FLASH_CYC    // Half period of run indicator flash
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [3:0]   avs_address,      // Word index
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    output logic              avs_readdatavalid_unused,
    input  wire dsm_monitor_t drive_monitor,    // Live values from drive
    input  wire logic         scan_end,         // End-of-scan instruction executed
    input  wire logic         alarm_valid,      // Drive fault occurred
    input  wire logic [7:0]   alarm_code,       // Fault class code
    input  wire logic         instr_is_contact, // Load/AND/OR/compare/output class
    input  wire logic         instr_exec_cond,  // Execution condition true
    input  wire logic         instr_check,      // Instruction being checked
    input  wire logic         operand_bad,      // Operand device unusable
    input  wire logic         opcode_bad,       // Instruction code undecodable
    input  wire logic         param_bad,        // Capacity over 1k or bad function
    input  wire logic         watchdog_expired, // Scan overran watchdog
    input  wire logic         end_missing,      // Scan ended without end instruction
    input  wire logic [15:0]  user_outputs,     // Program outputs
    output logic [15:0]       drive_outputs,    // Outputs to drive, cleared on stop
    output logic              run_led,          // Program run indicator
    output logic              irq               // Level interrupt
);
    `include "dsm_defines.svh"
    dsm_state_t  state;                 // Scan controller state
    dsm_state_t  next_state;
    logic [15:0] freq_mon;              // Frequency monitor word
    logic [15:0] curr_mon;              // Current monitor word
    logic [15:0] volt_mon;              // Voltage monitor word
    logic [63:0] hist_words;            // Packed history words
    logic [7:0]  diag_num;              // Self-diagnostic error number
    logic [`DSM_STAT_W-1:0] status;     // Sticky event bits
    logic [`DSM_STAT_W-1:0] mask;       // Interrupt enables
    logic [`DSM_STAT_W-1:0] events;     // Events this cycle
    logic        run_enable;            // Software run request
    logic [31:0] flash_cnt;             // Flash timer
    logic        flash;                 // Flash phase
    logic        rd_pending;            // Read data registered, answer next cycle
    dsm_diag_t   diag;                  // Fault reports this cycle
    logic        check_now;             // Operand check active
    logic        stopped;

    // Decides whether an operand is validated this cycle
    function automatic logic operand_checked(input logic contact, input logic cond);
        return contact || cond;
    endfunction

    // Truncate frequency down to the 0.1 Hz step the output really runs at
    function automatic logic [15:0] freq_quantise(input logic [15:0] f);
        return f - (f % `DSM_FREQ_STEP);
    endfunction

    assign check_now = instr_check && operand_checked(instr_is_contact, instr_exec_cond);
    assign diag.bad_instruction_error  = check_now && (opcode_bad || operand_bad);
    assign diag.param_error            = param_bad;
    assign diag.scan_overrun_error     = watchdog_expired;
    assign diag.missing_scan_end_error = end_missing;
    assign stopped = (state == DSM_STOP);

    // Next state: any fault during a scan stops execution until reset
    always_comb begin
        next_state = state;
        case (state)
            DSM_RUN: begin
                if (run_enable) begin
                    next_state = DSM_SCAN;
                end
            end
            DSM_SCAN: begin
                if (diag != '0) begin
                    next_state = DSM_STOP;
                end else if (!run_enable) begin
                    next_state = DSM_RUN;
                end
            end
            DSM_STOP: begin
                next_state = DSM_STOP;
            end
            default: begin
                next_state = DSM_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= DSM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Error number capture; priority follows number order
    always_ff @(posedge clk) begin
        if (rst) begin
            diag_num <= 8'h00;
        end else if (state == DSM_SCAN) begin
            if (diag.bad_instruction_error) begin
                diag_num <= `DSM_ERR_BAD_INSTR;
            end else if (diag.param_error) begin
                diag_num <= `DSM_ERR_PARAM;
            end else if (diag.scan_overrun_error) begin
                diag_num <= `DSM_ERR_OVERRUN;
            end else if (diag.missing_scan_end_error) begin
                diag_num <= `DSM_ERR_NO_END;
            end
        end
    end

    // Monitor refresh at end of scan; writes never reach these
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_mon <= `DSM_RST_WORD;
            curr_mon <= `DSM_RST_WORD;
            volt_mon <= `DSM_RST_WORD;
        end else if (scan_end) begin
            freq_mon <= freq_quantise(drive_monitor.freq);
            curr_mon <= drive_monitor.curr;
            volt_mon <= drive_monitor.volt;
        end
    end

    // History keeps recording drive faults in any state
    dsm_error_history u_hist (
        .clk     (clk),
        .rst     (rst),
        .push    (alarm_valid),
        .code    (alarm_code),
        .publish (scan_end),
        .words   (hist_words)
    );

    // Outputs follow the program, cleared while stopped
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_outputs <= 16'h0000;
        end else if (stopped) begin
            drive_outputs <= 16'h0000;
        end else if (scan_end) begin
            drive_outputs <= user_outputs;
        end
    end

    // Run indicator: steady while running, flashing after a fault
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_cnt <= 32'h0;
            flash     <= 1'b0;
            run_led   <= 1'b0;
        end else begin
            if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
                flash_cnt <= 32'h0;
                flash     <= ~flash;
            end else begin
                flash_cnt <= flash_cnt + 32'h1;
            end
            if (stopped) begin
                run_led <= flash;
            end else begin
                run_led <= (state == DSM_SCAN);
            end
        end
    end

    // Events feeding the sticky status bits
    always_comb begin
        events = '0;
        events[`DSM_STAT_HIST] = alarm_valid && (alarm_code != `DSM_NO_ALARM);
        events[`DSM_STAT_DIAG] = (state == DSM_SCAN) && (diag != '0);
        events[`DSM_STAT_SCAN] = scan_end;
    end

    // Sticky status, cleared by a read; a new event wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else if (rd_pending && avs_address == `DSM_OFF_STATUS) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    assign irq = |(status & mask);

    // Software-writable control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mask       <= '0;
            run_enable <= 1'b0;
        end else if (avs_write) begin
            case (avs_address)
                `DSM_OFF_MASK: begin
                    mask <= avs_writedata[`DSM_STAT_W-1:0];
                end
                `DSM_OFF_CONTROL: begin
                    run_enable <= avs_writedata[0];
                end
                default: begin
                    // Monitor and history words ignore writes
                end
            endcase
        end
    end

    // Reads take two cycles: one wait, then data stands with waitrequest low
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pending <= 1'b0;
        end else begin
            rd_pending <= avs_read && !rd_pending;
        end
    end

    assign avs_waitrequest = avs_read && !rd_pending;
    assign avs_readdatavalid_unused = 1'b0;

    // Read data mux; unmapped words read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !rd_pending) begin
            case (avs_address)
                `DSM_OFF_FREQ:    avs_readdata <= {16'h0, freq_mon};
                `DSM_OFF_CURR:    avs_readdata <= {16'h0, curr_mon};
                `DSM_OFF_VOLT:    avs_readdata <= {16'h0, volt_mon};
                `DSM_OFF_HIST0:   avs_readdata <= {16'h0, hist_words[15:0]};
                `DSM_OFF_HIST1:   avs_readdata <= {16'h0, hist_words[31:16]};
                `DSM_OFF_HIST2:   avs_readdata <= {16'h0, hist_words[47:32]};
                `DSM_OFF_HIST3:   avs_readdata <= {16'h0, hist_words[63:48]};
                `DSM_OFF_DIAG:    avs_readdata <= {24'h0, diag_num};
                `DSM_OFF_STATUS:  avs_readdata <= {29'h0, status};
                `DSM_OFF_MASK:    avs_readdata <= {29'h0, mask};
                `DSM_OFF_CONTROL: avs_readdata <= {29'h0, state};
                default:          avs_readdata <= 32'h0;
            endcase
        end
    end
endmodule

// ==== dsm_monitor_bank_asserts.sv ====
// Port-level checks on the drive status monitor bank
`timescale 1ns/1ps
module dsm_monitor_bank_asserts #(
    parameter int FLASH_CYC = 4          // Flash half period
)(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        scan_end,
    input wire logic        param_bad,
    input wire logic        watchdog_expired,
    input wire logic        end_missing,
    input wire logic [15:0] drive_outputs,
    input wire logic        run_led,
    input wire logic        irq
);
    localparam int LIM = 2 * FLASH_CYC + 4; // Slack for flash phase
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    // Fault while scanning
    sequence s_fault;
        run_led && (param_bad || watchdog_expired || end_missing);
    endsequence
    // Outputs held clear
    sequence s_cleared;
        (drive_outputs == 16'h0000)[*4];
    endsequence
    property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_idle; !avs_read |-> !avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait without read");
    property p_rd_first; $rose(avs_read) |-> avs_waitrequest; endproperty
    a_rd_first: assert property (p_rd_first) else $error("read not held");
    property p_rd_bound; avs_read |-> ##[0:1] !avs_waitrequest; endproperty
    a_rd_bound: assert property (p_rd_bound) else $error("read stuck");
    property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_stop; s_fault |-> ##[1:3] s_cleared; endproperty
    a_stop: assert property (p_stop) else $error("outputs not cleared");
    property p_outs; $changed(drive_outputs) |-> $past(scan_end) || drive_outputs == 16'h0000; endproperty
    a_outs: assert property (p_outs) else $error("outputs moved off scan");
    property p_irq_fall; $fell(irq) |-> $past(avs_read || avs_write); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    property p_flash; s_fault |-> ##[1:LIM] $changed(run_led); endproperty
    a_flash: assert property (p_flash) else $error("indicator not flashing");
endmodule
bind dsm_monitor_bank dsm_monitor_bank_asserts #(.FLASH_CYC(FLASH_CYC)) u_chk (
    .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scan_end(scan_end), .param_bad(param_bad), .watchdog_expired(watchdog_expired),
    .end_missing(end_missing), .drive_outputs(drive_outputs), .run_led(run_led), .irq(irq));

// ==== dsm_monitor_bank_tb.sv ====
// Self-checking bench for the drive status monitor bank
`timescale 1ns/1ps
module dsm_monitor_bank_tb import dsm_pkg::*;;
    logic         clk, rst, avs_read, avs_write, avs_waitrequest;
    logic         scan_end, alarm_valid, run_led, irq;
    logic         instr_is_contact, instr_exec_cond, instr_check;
    logic         operand_bad, opcode_bad, param_bad, watchdog_expired, end_missing;
    logic [3:0]   avs_address;
    logic [7:0]   alarm_code;
    logic [15:0]  user_outputs, drive_outputs;
    logic [31:0]  avs_writedata, avs_readdata, d;
    dsm_monitor_t mon;                   // Live drive sample
    int           bad_count, n_compared;
    logic [7:0]   nums [4] = '{8'h0a, 8'h0b, 8'h16, 8'h18}; // Diag numbers

    dsm_monitor_bank #(.FLASH_CYC(4)) u_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_readdatavalid_unused(),
        .drive_monitor(mon), .scan_end(scan_end), .alarm_valid(alarm_valid),
        .alarm_code(alarm_code), .instr_is_contact(instr_is_contact),
        .instr_exec_cond(instr_exec_cond), .instr_check(instr_check),
        .operand_bad(operand_bad), .opcode_bad(opcode_bad), .param_bad(param_bad),
        .watchdog_expired(watchdog_expired), .end_missing(end_missing),
        .user_outputs(user_outputs), .drive_outputs(drive_outputs),
        .run_led(run_led), .irq(irq));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus write, never stalls but honour waitrequest anyway
    task wr(input logic [3:0] a, input logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // Bus read, data taken at the edge waitrequest is low
    task rd(input logic [3:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task rc(input logic [3:0] a, input logic [31:0] e);
        rd(a, d);
        chk(d, e);
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    // One end-of-scan pulse
    task pulse_scan;
        scan_end <= 1'b1;
        @(posedge clk);
        scan_end <= 1'b0;
        @(posedge clk);
    endtask
    // Live monitors, refresh only at scan end
    task t_mon;
        do_reset();
        mon <= {16'h1775, 16'h00c8, 16'h03e8};
        rc(4'h0, 32'h0);
        pulse_scan();
        rc(4'h0, 32'h1770);
        rc(4'h1, 32'h00c8);
        rc(4'h2, 32'h03e8);
        wr(4'h0, 32'h1234);
        rc(4'h0, 32'h1770);
        rc(4'hb, 32'h0);
        $display("monitor test done");
    endtask
    // Nine alarms, newest eight kept, irq through status
    task t_hist;
        wr(4'h9, 32'h7);
        for (int i = 0; i < 10; i++) begin
            alarm_valid <= 1'b1;
            alarm_code <= (i == 5) ? 8'h00 : 8'h10 + 8'(i - (i > 5));
            @(posedge clk);
            alarm_valid <= 1'b0;
            @(posedge clk);
        end
        rc(4'h3, 32'h0);
        pulse_scan();
        for (int k = 0; k < 4; k++) begin
            rc(4'(3 + k), {16'h0, 8'h18 - 8'(2 * k + 1), 8'h18 - 8'(2 * k)});
        end
        chk(irq, 1'b1);
        rc(4'h8, 32'h5);
        chk(irq, 1'b0);
        rc(4'h8, 32'h0);
        $display("history test done");
    endtask
    // Fault stop: number, cleared outputs, flashing indicator
    task t_fault(input int k, input logic [7:0] num);
        int   n;
        logic l;
        do_reset();
        wr(4'ha, 32'h1);
        user_outputs <= 16'ha5a5;
        pulse_scan();
        chk(drive_outputs, 16'ha5a5);
        wr(4'ha, 32'h1);
        {instr_check, operand_bad} <= 2'b11;
        @(posedge clk);
        {instr_check, operand_bad} <= 2'b00;
        rc(4'ha, 32'h2);
        chk(run_led, 1'b1);
        case (k)
            0: {instr_check, instr_is_contact, opcode_bad} <= 3'b111;
            1: param_bad <= 1'b1;
            2: watchdog_expired <= 1'b1;
            default: end_missing <= 1'b1;
        endcase
        @(posedge clk);
        {instr_check, instr_is_contact, opcode_bad, param_bad, watchdog_expired, end_missing} <= '0;
        d = '0;
        for (int i = 0; i < 8 && d !== 32'h4; i++) rd(4'ha, d);
        chk(d, 32'h4);
        chk(drive_outputs, 16'h0);
        rc(4'h7, {24'h0, num});
        n = 0;
        l = run_led;
        repeat (12) begin
            @(posedge clk);
            n += (run_led !== l);
            l = run_led;
        end
        chk(n > 1, 1'b1);
        $display("fault test %0d done", k);
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {avs_read, avs_write, scan_end, alarm_valid, instr_is_contact, instr_exec_cond} = '0;
        {instr_check, operand_bad, opcode_bad, param_bad, watchdog_expired, end_missing} = '0;
        {avs_address, alarm_code, user_outputs, avs_writedata, mon} = '0;
        rst = 1'b1;
        t_mon();
        t_hist();
        for (int k = 0; k < 4; k++) t_fault(k, nums[k]);
        tally_and_finish();
    end
endmodule
